// ---- src/mcr_params.svh ----
// register offsets, field positions, reset values and timing counts for the motor control register block
`ifndef MCR_PARAMS_SVH
`define MCR_PARAMS_SVH

`define MCR_ADDR_W 4
`define MCR_OFF_MAIN 4'h0
`define MCR_OFF_PHASE 4'h1
`define MCR_OFF_OUTMODE 4'h2
`define MCR_OFF_SAMPLING 4'h3
`define MCR_OFF_FILTER 4'h4
`define MCR_OFF_PREV 4'h5
`define MCR_OFF_CURR 4'h6
`define MCR_OFF_COMPARE 4'h7
`define MCR_OFF_WEIGHT 4'h8
`define MCR_OFF_EVENT 4'h9
`define MCR_OFF_STATUS 4'hA

`define MCR_MAIN_RESET 8'h00
`define MCR_BIT_GATE 7
`define MCR_BIT_CLKEN 6
`define MCR_BIT_SENSOR 5
`define MCR_BIT_DIRECT 4
`define MCR_BIT_REGMODE 3
`define MCR_BIT_AUTO 2
`define MCR_BIT_PZGUARD 1
`define MCR_BIT_OPERAND 0

`define MCR_BIT_OS0 0
`define MCR_BIT_OS1 1
`define MCR_BIT_OS2 2
`define MCR_BIT_HDM 5
`define MCR_BIT_SDM 4
`define MCR_BIT_FASTZ 0
`define MCR_BIT_ZKEEP 0

`define MCR_PWM_W 12
`define MCR_PWM_PERIOD 12'hFFF
`define MCR_SAMPLE_DIV 4'hF

`endif

// ---- src/mcr_pkg.sv ----
// types shared by the motor control register block
`include "mcr_params.svh"
package mcr_pkg;

    typedef struct packed {
        logic phase_output_gate;
        logic clk_enable;
        logic position_sensor_select;
        logic direct_access;
        logic regulation_mode_select;
        logic autocommutate_select;
        logic parasitic_zero_guard;
        logic multiplier_operand_select;
    } mcr_main_s;

    typedef struct packed {
        logic [`MCR_ADDR_W-1:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } mcr_bus_s;

    typedef enum logic [1:0] {
        MCR_RST_HIZ = 2'b00,
        MCR_RST_HIGH = 2'b01,
        MCR_RST_LOW = 2'b10
    } mcr_rst_mode_e;

    typedef enum logic [1:0] {
        MCR_ST_C2D = 2'b00,
        MCR_ST_D2Z = 2'b01,
        MCR_ST_Z2C = 2'b10
    } mcr_step_e;

endpackage

// ---- src/mcr_main.sv ----
// main control register of the motor controller with output gating and multiplier load
`timescale 1ns/1ns
`default_nettype none
`include "mcr_params.svh"

// Overview of operation
// (R1) outputs held in reset state while gate bit 7 is zero
// (R2) each output reset state is hi-z, high or low from an option input
// (R3) clock bit 6 zero stops delay manager, sampling, PWM, events and preloads
// (R4) register writes work while internal clocks are off
// (R5) clocks off, outputs on, direct off: outputs freeze
// (R6) direct access: static levels without clocks, PWM allowed with clocks
// (R7) clocks stopped: PWM outputs high in voltage mode, low in current mode
// (R8) software should clear output gate before clearing clock enable
// (R9) PWM counter cleared while clocks off; enabling transfers update preloads
// (R10) bit 5 picks sensorless three intervals or sensor two intervals
// (R11) without direct access, preloads apply at next commutation event
// (R12) direct access: phase write drives outputs and makes commutation event
// (R13) bit 3 selects voltage or current regulation
// (R14) bit 2 selects switched or autoswitched; compare stays read-write
// (R15) bit 1 enables parasitic zero guard and ignores zero filter
// (R16) bit 0 picks previous or current capture as multiplier operand
// (R17) gate off, sensorless, slow sampling: keep bit decides zero sampling
// (R18) main control resets to zero
// (R19) autoswitched: each zero event loads compare with weight times capture over 256
// (R20) preloaded output mode and demag bits take effect at commutation
// (R21) a write updates all eight bits at once; reads return them
module mcr_main
    import mcr_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    input wire logic [`MCR_ADDR_W-1:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    input wire logic [11:0] i_rst_option,
    input wire logic i_zero_event,
    input wire logic i_comm_event,
    output logic [5:0] o_phase_out,
    output logic [5:0] o_phase_oe_n,
    output logic o_zero_sample_en,
    output logic o_demag_sample_en,
    output logic o_comm_pulse,
    output logic o_update_pulse,
    output logic o_zfilter_bypass
);

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    mcr_bus_s bus;
    assign bus = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};

    wire logic wr_main = bus.wr && (bus.addr == `MCR_OFF_MAIN);
    wire logic wr_phase = bus.wr && (bus.addr == `MCR_OFF_PHASE);
    wire logic wr_mode = bus.wr && (bus.addr == `MCR_OFF_OUTMODE);
    wire logic wr_samp = bus.wr && (bus.addr == `MCR_OFF_SAMPLING);
    wire logic wr_filt = bus.wr && (bus.addr == `MCR_OFF_FILTER);
    wire logic wr_prev = bus.wr && (bus.addr == `MCR_OFF_PREV);
    wire logic wr_curr = bus.wr && (bus.addr == `MCR_OFF_CURR);
    wire logic wr_comp = bus.wr && (bus.addr == `MCR_OFF_COMPARE);
    wire logic wr_wght = bus.wr && (bus.addr == `MCR_OFF_WEIGHT);
    wire logic wr_evt = bus.wr && (bus.addr == `MCR_OFF_EVENT);

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    mcr_main_s main_reg;
    logic [7:0] phase_pre_reg;
    logic [7:0] phase_act_reg;
    logic [7:0] mode_pre_reg;
    logic [7:0] mode_act_reg;
    logic [7:0] samp_reg;
    logic [3:0] filt_reg;
    logic [7:0] prev_reg;
    logic [7:0] curr_reg;
    logic [7:0] comp_reg;
    logic [7:0] wght_reg;
    logic [7:0] evt_reg;
    logic [11:0] pwm_cnt_reg;
    logic [11:0] duty_pre_reg;
    logic [11:0] duty_act_reg;
    logic [3:0] samp_div_reg;
    logic clken_d_reg;
    logic [1:0] step_reg;
    logic [1:0] zev_sync_reg;
    logic [1:0] cev_sync_reg;
    logic zev_d_reg;
    logic cev_d_reg;
    logic [5:0] out_reg;
    logic [5:0] oe_n_reg;
    logic [7:0] rdata_reg;
    logic zs_reg;
    logic ds_reg;
    logic comm_reg;
    logic upd_reg;
    logic zbyp_reg;

    // scaled product, weight times capture over 256
    function automatic logic [7:0] mcr_scale(input logic [7:0] w, input logic [7:0] z);
        logic [15:0] p;
        p = 16'(w) * 16'(z);
        return p[15:8];
    endfunction

    // ------------------------------------------------------------
    // event detection and derived controls
    // ------------------------------------------------------------
    wire logic clk_on = main_reg.clk_enable;
    wire logic zev_edge = zev_sync_reg[1] && !zev_d_reg;
    wire logic cev_edge = cev_sync_reg[1] && !cev_d_reg;
    wire logic zero_evt = clk_on && zev_edge; // R3
    wire logic direct_comm = main_reg.direct_access && wr_phase; // R12
    wire logic comm_evt = (clk_on && cev_edge && !main_reg.direct_access) || direct_comm; // R3
    wire logic enable_rise = clk_on && !clken_d_reg;
    wire logic pwm_wrap = clk_on && (pwm_cnt_reg == `MCR_PWM_PERIOD);
    wire logic update_evt = enable_rise || pwm_wrap; // R9
    wire logic pwm_level = clk_on && (pwm_cnt_reg < duty_act_reg);
    wire logic samp_tick = clk_on && (samp_div_reg == `MCR_SAMPLE_DIV); // R3
    wire logic [7:0] operand = main_reg.multiplier_operand_select ? curr_reg : prev_reg; // R16
    wire logic [7:0] comp_auto = mcr_scale(wght_reg, operand); // R19

    // ------------------------------------------------------------
    // phase drive selection
    // ------------------------------------------------------------
    // pwm side: sensor mode skips the middle interval, direct uses bit zero only
    logic pwm_on_low;
    always_comb begin
        if (main_reg.direct_access) begin
            pwm_on_low = mode_act_reg[`MCR_BIT_OS0]; // R12
        end else begin
            case (step_reg)
                MCR_ST_C2D: pwm_on_low = mode_act_reg[`MCR_BIT_OS2]; // R10
                MCR_ST_D2Z: pwm_on_low = mode_act_reg[`MCR_BIT_OS1]; // R10
                MCR_ST_Z2C: pwm_on_low = mode_act_reg[`MCR_BIT_OS0];
                default: pwm_on_low = 1'b0;
            endcase
        end
    end

    // phase bits: even index high side, odd index low side
    logic [5:0] drive_val;
    always_comb begin
        for (int i = 0; i < 6; i++) begin
            if (!phase_act_reg[i]) begin
                drive_val[i] = 1'b0;
            end else if ((i % 2 == 1) != pwm_on_low) begin
                drive_val[i] = 1'b1;
            end else if (clk_on) begin
                drive_val[i] = pwm_level; // R6
            end else if (main_reg.direct_access) begin
                drive_val[i] = 1'b1; // R6
            end else begin
                drive_val[i] = !main_reg.regulation_mode_select; // R7 R13
            end
        end
    end

    // ------------------------------------------------------------
    // output gating and reset state
    // ------------------------------------------------------------
    logic [5:0] out_next;
    logic [5:0] oe_n_next;
    always_comb begin
        for (int i = 0; i < 6; i++) begin
            if (!main_reg.phase_output_gate) begin // R1
                case (mcr_rst_mode_e'(i_rst_option[2*i +: 2])) // R2
                    MCR_RST_HIGH: begin
                        out_next[i] = 1'b1;
                        oe_n_next[i] = 1'b0;
                    end
                    MCR_RST_LOW: begin
                        out_next[i] = 1'b0;
                        oe_n_next[i] = 1'b0;
                    end
                    default: begin
                        out_next[i] = 1'b0;
                        oe_n_next[i] = 1'b1;
                    end
                endcase
            end else if (!clk_on && !main_reg.direct_access) begin
                // frozen: events and preloads stop, pwm sides settle per mode
                out_next[i] = drive_val[i]; // R5 R7
                oe_n_next[i] = 1'b0;
            end else begin
                out_next[i] = drive_val[i];
                oe_n_next[i] = 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // zero sampling and read data
    // ------------------------------------------------------------
    // zero sampling: with gate off in sensorless slow sampling, keep bit decides
    wire logic z_keep = samp_reg[`MCR_BIT_ZKEEP];
    wire logic fast_z = evt_reg[`MCR_BIT_FASTZ];
    wire logic z_sample_gate = (!main_reg.phase_output_gate && !main_reg.position_sensor_select
        && !fast_z) ? z_keep : 1'b1; // R17

    logic [7:0] rdata_next;
    always_comb begin
        case (bus.addr)
            `MCR_OFF_MAIN: rdata_next = main_reg; // R21
            `MCR_OFF_PHASE: rdata_next = phase_pre_reg;
            `MCR_OFF_OUTMODE: rdata_next = mode_pre_reg;
            `MCR_OFF_SAMPLING: rdata_next = samp_reg;
            `MCR_OFF_FILTER: rdata_next = {4'h0, filt_reg};
            `MCR_OFF_PREV: rdata_next = prev_reg;
            `MCR_OFF_CURR: rdata_next = curr_reg;
            `MCR_OFF_COMPARE: rdata_next = comp_reg; // R14
            `MCR_OFF_WEIGHT: rdata_next = wght_reg;
            `MCR_OFF_EVENT: rdata_next = evt_reg;
            `MCR_OFF_STATUS: rdata_next = {4'h0, pwm_on_low, step_reg, clk_on};
            default: rdata_next = 8'h00;
        endcase
    end

    // ------------------------------------------------------------
    // sequential logic
    // ------------------------------------------------------------
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            main_reg <= `MCR_MAIN_RESET; // R18
            phase_pre_reg <= 8'h00;
            mode_pre_reg <= 8'h00;
            samp_reg <= 8'h00;
            filt_reg <= 4'h0;
            wght_reg <= 8'h00;
            evt_reg <= 8'h00;
            prev_reg <= 8'h00;
            curr_reg <= 8'h00;
        end else begin
            if (wr_main) main_reg <= bus.wdata; // R4 R21
            if (wr_phase) phase_pre_reg <= bus.wdata;
            if (wr_mode) mode_pre_reg <= bus.wdata;
            if (wr_samp) samp_reg <= bus.wdata;
            if (wr_filt) filt_reg <= bus.wdata[3:0];
            if (wr_wght) wght_reg <= bus.wdata;
            if (wr_evt) evt_reg <= bus.wdata;
            if (zero_evt) begin
                prev_reg <= curr_reg;
            end else if (wr_prev) begin
                prev_reg <= bus.wdata;
            end
            if (wr_curr) curr_reg <= bus.wdata;
        end
    end

    // ------------------------------------------------------------
    // multiplier load
    // ------------------------------------------------------------
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            comp_reg <= 8'h00;
        end else if (zero_evt && main_reg.autocommutate_select) begin
            comp_reg <= comp_auto; // R19
        end else if (wr_comp) begin
            comp_reg <= bus.wdata; // R14
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            phase_act_reg <= 8'h00;
            mode_act_reg <= 8'h00;
        end else if (comm_evt) begin
            phase_act_reg <= wr_phase ? bus.wdata : phase_pre_reg; // R11 R12
            mode_act_reg <= mode_pre_reg; // R20
        end else if (update_evt) begin
            mode_act_reg[1:0] <= mode_pre_reg[1:0];
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            pwm_cnt_reg <= 12'h000;
            duty_pre_reg <= 12'h000;
            duty_act_reg <= 12'h000;
            samp_div_reg <= 4'h0;
            clken_d_reg <= 1'b0;
        end else begin
            clken_d_reg <= clk_on;
            pwm_cnt_reg <= clk_on ? pwm_cnt_reg + 12'h001 : 12'h000; // R9
            samp_div_reg <= clk_on ? samp_div_reg + 4'h1 : 4'h0; // R3
            if (wr_samp) duty_pre_reg <= {bus.wdata, 4'h0};
            if (update_evt) duty_act_reg <= duty_pre_reg; // R9
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            step_reg <= MCR_ST_C2D;
        end else if (comm_evt) begin
            step_reg <= MCR_ST_C2D;
        end else if (zero_evt) begin
            step_reg <= MCR_ST_Z2C;
        end else if (samp_tick && step_reg == MCR_ST_C2D && !main_reg.position_sensor_select) begin
            step_reg <= MCR_ST_D2Z; // R10
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            zev_sync_reg <= 2'b00;
            cev_sync_reg <= 2'b00;
            zev_d_reg <= 1'b0;
            cev_d_reg <= 1'b0;
        end else begin
            zev_sync_reg <= {zev_sync_reg[0], i_zero_event};
            cev_sync_reg <= {cev_sync_reg[0], i_comm_event};
            zev_d_reg <= zev_sync_reg[1];
            cev_d_reg <= cev_sync_reg[1];
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            out_reg <= 6'h00;
            oe_n_reg <= 6'h3F;
            rdata_reg <= 8'h00;
            zs_reg <= 1'b0;
            ds_reg <= 1'b0;
            comm_reg <= 1'b0;
            upd_reg <= 1'b0;
            zbyp_reg <= 1'b0;
        end else begin
            out_reg <= out_next;
            oe_n_reg <= oe_n_next;
            rdata_reg <= bus.rd ? rdata_next : 8'h00;
            zs_reg <= samp_tick && z_sample_gate; // R17
            ds_reg <= samp_tick && (mode_act_reg[`MCR_BIT_HDM] || mode_act_reg[`MCR_BIT_SDM]);
            comm_reg <= comm_evt;
            upd_reg <= update_evt;
            zbyp_reg <= main_reg.parasitic_zero_guard; // R15
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign o_rdata = rdata_reg;
    assign o_phase_out = out_reg;
    assign o_phase_oe_n = oe_n_reg;
    assign o_zero_sample_en = zs_reg;
    assign o_demag_sample_en = ds_reg;
    assign o_comm_pulse = comm_reg;
    assign o_update_pulse = upd_reg;
    assign o_zfilter_bypass = zbyp_reg;

endmodule
`default_nettype wire

// ---- test/mcr_main_monitor.sv ----
// assertion checker for the motor control register block
`timescale 1ns/1ns
`default_nettype none
`include "mcr_params.svh"
module mcr_main_monitor (
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    input wire logic [`MCR_ADDR_W-1:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [7:0] o_rdata,
    input wire logic [11:0] i_rst_option,
    input wire logic [5:0] o_phase_out,
    input wire logic [5:0] o_phase_oe_n,
    input wire logic o_zero_sample_en,
    input wire logic o_comm_pulse,
    input wire logic o_update_pulse,
    input wire logic o_zfilter_bypass
);
    // ----------------------------------------
    // mirror of the main control register
    // ----------------------------------------
    logic [7:0] main_m;
    logic [5:0] hiz_m;
    logic [5:0] lvl_m;
    wire gate = main_m[`MCR_BIT_GATE];
    wire ck = main_m[`MCR_BIT_CLKEN];
    wire dir = main_m[`MCR_BIT_DIRECT];
    wire ph_wr = i_wr && (i_addr == `MCR_OFF_PHASE);
    for (genvar g = 0; g < 6; g++) begin : g_opt
        assign hiz_m[g] = ~^i_rst_option[2*g+:2];
        assign lvl_m[g] = i_rst_option[2*g];
    end
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            main_m <= 8'h00;
        end else if (i_wr && i_addr == `MCR_OFF_MAIN) begin
            main_m <= i_wdata;
        end
    end
    // ----------------------------------------
    // properties
    // ----------------------------------------
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_reset_n);
    sequence s_gate_off;
        !gate [*3];
    endsequence
    sequence s_clk_off;
        !ck [*3];
    endsequence
    sequence s_wr_rd;
        (i_wr && i_addr == `MCR_OFF_MAIN) ##1 (i_rd && i_addr == `MCR_OFF_MAIN);
    endsequence
    a_gate_reset_state: assert property (s_gate_off |-> o_phase_oe_n == hiz_m
        && (o_phase_out & ~hiz_m) == (lvl_m & ~hiz_m)) else $error("reset state wrong");
    a_clk_off_quiet: assert property (s_clk_off |-> !o_zero_sample_en
        && !o_update_pulse) else $error("event with clocks off");
    a_update_on_enable: assert property ($rose(ck) |-> ##[1:3] o_update_pulse)
        else $error("no update on enable");
    a_read_main: assert property (i_rd && i_addr == `MCR_OFF_MAIN
        |=> o_rdata == $past(main_m)) else $error("main read wrong");
    a_read_unmapped: assert property (i_rd && i_addr > `MCR_OFF_STATUS
        |=> o_rdata == 8'h00) else $error("unmapped read not zero");
    a_read_idle: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
        else $error("read data outside read");
    a_write_readback: assert property (s_wr_rd |=> o_rdata == $past(i_wdata, 2))
        else $error("readback wrong");
    a_guard_level: assert property ($stable(main_m[1])
        |-> o_zfilter_bypass == main_m[1]) else $error("guard level wrong");
    a_direct_comm: assert property (ph_wr && dir |=> o_comm_pulse)
        else $error("no commutation on direct write");
    a_direct_static: assert property (ph_wr && dir && gate && !ck |-> ##2
        o_phase_out == $past(i_wdata[5:0], 2) && o_phase_oe_n == 6'h00)
        else $error("direct level wrong");
endmodule

bind mcr_main mcr_main_monitor u_mcr_main_monitor (
    .i_clk_sys(i_clk_sys),
    .i_reset_n(i_reset_n),
    .i_addr(i_addr),
    .i_wdata(i_wdata),
    .i_wr(i_wr),
    .i_rd(i_rd),
    .o_rdata(o_rdata),
    .i_rst_option(i_rst_option),
    .o_phase_out(o_phase_out),
    .o_phase_oe_n(o_phase_oe_n),
    .o_zero_sample_en(o_zero_sample_en),
    .o_comm_pulse(o_comm_pulse),
    .o_update_pulse(o_update_pulse),
    .o_zfilter_bypass(o_zfilter_bypass)
);
`default_nettype wire

// ---- test/mcr_inverter_model.sv ----
// inverter power stage model with a back-emf zero-crossing comparator
`timescale 1ns/1ns
`default_nettype none
module mcr_inverter_model (
    input wire logic i_clk_sys,
    input wire logic [5:0] i_phase_out,
    input wire logic [5:0] i_phase_oe_n,
    input wire logic i_zero_req,
    output logic [5:0] o_pin,
    output logic o_zero_event,
    output logic o_comm_event
);
    logic [2:0] hold_reg = 3'h0;
    // released gate lines float
    for (genvar g = 0; g < 6; g++) begin : g_pin
        assign o_pin[g] = i_phase_oe_n[g] ? 1'bz : i_phase_out[g];
    end
    // comparator output stays high a few cycles per crossing
    always_ff @(posedge i_clk_sys) begin
        hold_reg <= i_zero_req ? 3'h4 : (hold_reg != 3'h0 ? hold_reg - 3'h1 : 3'h0);
    end
    assign o_zero_event = (hold_reg != 3'h0);
    assign o_comm_event = 1'b0;
endmodule
`default_nettype wire

// ---- test/mcr_main_tb_top.sv ----
// self-checking testbench for the motor control register block
`timescale 1ns/1ns
`default_nettype none
`include "mcr_params.svh"
module mcr_main_tb_top;
    logic i_clk_sys, i_reset_n, i_wr, i_rd, zero_req, zero_ev, comm_ev;
    logic [`MCR_ADDR_W-1:0] i_addr;
    logic [7:0] i_wdata, o_rdata, rd_val;
    logic [11:0] i_rst_option;
    logic [5:0] o_phase_out, o_phase_oe_n, pin;
    logic o_zero_sample_en, o_demag_sample_en, o_comm_pulse, o_update_pulse, o_zfilter_bypass;
    wire [2:0] flags = {o_demag_sample_en, o_zero_sample_en, o_update_pulse};
    int errors, tests_run;

    mcr_main u_mcr_main (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_rst_option(i_rst_option), .i_zero_event(zero_ev), .i_comm_event(comm_ev),
        .o_phase_out(o_phase_out), .o_phase_oe_n(o_phase_oe_n),
        .o_zero_sample_en(o_zero_sample_en), .o_demag_sample_en(o_demag_sample_en),
        .o_comm_pulse(o_comm_pulse), .o_update_pulse(o_update_pulse),
        .o_zfilter_bypass(o_zfilter_bypass));
    mcr_inverter_model u_mcr_inverter_model (.i_clk_sys(i_clk_sys), .i_phase_out(o_phase_out),
        .i_phase_oe_n(o_phase_oe_n), .i_zero_req(zero_req), .o_pin(pin),
        .o_zero_event(zero_ev), .o_comm_event(comm_ev));

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp) begin
            $display("ERROR %s expected %h seen %h", name, exp, got);
            errors++;
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_clk_sys);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk_sys);
        i_wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] v);
        @(posedge i_clk_sys);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk_sys);
        i_rd <= 1'b0;
        #1;
        v = o_rdata;
    endtask
    task automatic wr_rd(input logic [3:0] a, input logic [7:0] d, output logic [7:0] v);
        @(posedge i_clk_sys);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk_sys);
        i_wr <= 1'b0;
        i_rd <= 1'b1;
        @(posedge i_clk_sys);
        i_rd <= 1'b0;
        #1;
        v = o_rdata;
    endtask
    task automatic zero_and_check(input string name, input logic [7:0] exp);
        @(posedge i_clk_sys);
        zero_req <= 1'b1;
        @(posedge i_clk_sys);
        zero_req <= 1'b0;
        for (int k = 0; k < 20; k++) begin
            rd(`MCR_OFF_COMPARE, rd_val);
            if (rd_val === exp) break;
        end
        chk(name, exp, rd_val);
    endtask
    task automatic wait_hi(input string name, input int sel, input int n);
        for (int k = 0; k < n; k++) begin
            @(posedge i_clk_sys);
            #1;
            if (flags[sel] === 1'b1) begin
                tests_run++;
                return;
            end
        end
        $display("ERROR %s expected 1 seen 0", name);
        errors++;
        tally_and_finish;
    endtask
    task tally_and_finish;
        $display("errors=%0d tests_run=%0d", errors, tests_run);
        if (errors == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task t_reset;
        rd(`MCR_OFF_MAIN, rd_val);
        chk("main reset", 8'h00, rd_val);
        wr(4'hF, 8'hFF);
        rd(4'hF, rd_val);
        chk("unmapped read", 8'h00, rd_val);
        chk("oe reset", 8'h09, {2'b00, o_phase_oe_n});
        chk("level reset", 8'h12, {2'b00, o_phase_out & ~o_phase_oe_n});
    endtask
    task t_regs;
        wr_rd(`MCR_OFF_MAIN, 8'h3F, rd_val);
        chk("main readback", 8'h3F, rd_val);
        chk("guard", 8'h01, {7'h00, o_zfilter_bypass});
        wr(`MCR_OFF_COMPARE, 8'h5A);
        rd(`MCR_OFF_COMPARE, rd_val);
        chk("compare rw", 8'h5A, rd_val);
        chk("oe gated", 8'h09, {2'b00, o_phase_oe_n});
        wr(`MCR_OFF_MAIN, 8'h00);
    endtask
    task t_direct;
        wr(`MCR_OFF_MAIN, 8'h90);
        wr(`MCR_OFF_PHASE, 8'h21);
        chk("comm pulse", 8'h01, {7'h00, o_comm_pulse});
        @(posedge i_clk_sys);
        #1;
        chk("direct out", 8'h21, {2'b00, o_phase_out});
        chk("direct oe", 8'h00, {2'b00, o_phase_oe_n});
        chk("pin level", 8'h21, {2'b00, pin});
        wr(`MCR_OFF_MAIN, 8'h10);
        @(posedge i_clk_sys);
        #1;
        chk("oe back", 8'h09, {2'b00, o_phase_oe_n});
        wr(`MCR_OFF_MAIN, 8'h00);
    endtask
    task t_frozen;
        wr(`MCR_OFF_MAIN, 8'h88);
        @(posedge i_clk_sys);
        #1;
        chk("frozen current", 8'h20, {2'b00, o_phase_out});
        wr(`MCR_OFF_MAIN, 8'h80);
        @(posedge i_clk_sys);
        #1;
        chk("frozen voltage", 8'h21, {2'b00, o_phase_out});
        wr(`MCR_OFF_MAIN, 8'h00);
    endtask
    task t_clock;
        int seen;
        seen = 0;
        wr(`MCR_OFF_OUTMODE, 8'h20);
        wr(`MCR_OFF_MAIN, 8'h70);
        wait_hi("update pulse", 0, 8);
        wr(`MCR_OFF_PHASE, 8'h00);
        wait_hi("sample tick", 1, 40);
        wait_hi("demag tick", 2, 40);
        wr(`MCR_OFF_MAIN, 8'h20);
        repeat (3) @(posedge i_clk_sys);
        repeat (40) begin
            @(posedge i_clk_sys);
            #1;
            if (flags !== 3'b000) seen++;
        end
        chk("quiet clocks off", 8'h00, seen[7:0]);
    endtask
    task t_auto;
        wr(`MCR_OFF_WEIGHT, 8'h80);
        wr(`MCR_OFF_CURR, 8'h40);
        wr(`MCR_OFF_PREV, 8'h10);
        wr(`MCR_OFF_MAIN, 8'h45);
        zero_and_check("compare load current", 8'h20);
        wr(`MCR_OFF_PREV, 8'h10);
        wr(`MCR_OFF_MAIN, 8'h44);
        zero_and_check("compare load previous", 8'h08);
        wr(`MCR_OFF_MAIN, 8'h00);
    endtask

    initial begin
        i_clk_sys = 1'b0;
        forever #20 i_clk_sys = ~i_clk_sys;
    end
    initial begin
        errors = 0;
        tests_run = 0;
        i_reset_n = 1'b0;
        i_wr = 1'b0;
        i_rd = 1'b0;
        i_addr = 4'h0;
        i_wdata = 8'h00;
        zero_req = 1'b0;
        i_rst_option = 12'h9E4;
        repeat (8) @(posedge i_clk_sys);
        i_reset_n <= 1'b1;
        t_reset;
        t_regs;
        t_direct;
        t_frozen;
        t_clock;
        t_auto;
        tally_and_finish;
    end
endmodule
`default_nettype wire
